/* rtl/prm_range_map.sv */
`default_nettype none
// Operation
// - Reject targets inside the safety margins below lower or above upper limit.
// - Factory default: mapping end 102,400, lower 1,200, upper 101,200.
// - Accepting a new mapping end recomputes both limits at once.
// - Lower limit is mapping end minus 253 rotations, upper minus 3 rotations.
// - Accept mapping end only if actual lies within lower-1 .. upper+1.
// - Mapping end bounded by actual plus 1,200 and 101,200, scaled den/num.
// - Scaled bounds are rounded to nearest integer when numerator and denominator differ.
// - Actual outside mapping end minus 256 rotations .. mapping end is shifted 256 rotations.
// - Measuring range is 256 rotations; usable range 250 rotations.
// - Steps per rotation equal 400 times denominator over numerator.
// - Writing actual derives referencing value; referencing value also writable directly.
// - Direction setting selects which shaft rotation increases position values.
module prm_range_map
  import prm_pkg::*;
(
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RSTN,
  // Physical position from the encoder, in steps
  input wire logic [31:0] I_PHYS_POS,
  // Register port
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  // Positioning request
  output logic O_RUN_REQ,
  output logic [31:0] O_TARGET,
  // Interrupt
  output logic O_IRQ
);
  // Encoder position comes from another domain: two flops first
  // A multi-bit word may tear while it moves, so it is taken only once two samples agree
  logic [31:0] phys_s1_reg, phys_s2_reg, phys_s3_reg;
  logic [31:0] phys_hold_reg, phys_hold_next;

  logic dir_reg, dir_next;
  logic [15:0] num_reg, num_next;
  logic [15:0] den_reg, den_next;
  logic [31:0] ref_reg, ref_next;
  logic [31:0] wrap_reg, wrap_next;
  logic [31:0] ume_reg, ume_next;
  prm_limits_t lim_reg, lim_next;
  prm_scale_t sc_reg, sc_next;
  prm_sc_state_t sc_st_reg, sc_st_next;
  logic [PRM_ST_W-1:0] status_reg, status_next;
  logic [PRM_ST_W-1:0] mask_reg, mask_next;
  logic [31:0] rdata_reg, rdata_next;
  logic run_reg, run_next;
  logic [31:0] target_reg, target_next;
  logic irq_reg, irq_next;
  logic div_start;
  logic [31:0] div_dvd;
  logic div_done;
  logic [31:0] div_quot;
  logic [PRM_ST_W-1:0] ev;
  logic st_clr;

  // Derived position and candidate values
  logic [31:0] dir_pos;
  logic [31:0] act_pos;
  logic signed [32:0] act_s;
  logic signed [32:0] wd_s;
  logic signed [32:0] cand_lo, cand_hi;
  logic signed [32:0] ume_min, ume_max;
  logic ume_ok;

  always_comb begin
    phys_hold_next = (phys_s2_reg == phys_s3_reg) ? phys_s2_reg : phys_hold_reg;
    dir_pos = dir_reg ? (32'h0 - phys_hold_reg) : phys_hold_reg;
    act_pos = dir_pos - ref_reg + wrap_reg;
    act_s = {act_pos[31], act_pos};
    wd_s = {I_WDATA[31], I_WDATA};
    cand_lo = wd_s - $signed({1'b0, sc_reg.span253});
    cand_hi = wd_s - $signed({1'b0, sc_reg.margin});
    ume_min = act_s + $signed({1'b0, sc_reg.margin});
    ume_max = act_s + $signed({1'b0, sc_reg.span253});
    ume_ok = (wd_s >= ume_min) && (wd_s <= ume_max) &&
      (act_s >= cand_lo - 33'sd1) && (act_s <= cand_hi + 33'sd1);
  end

  prm_rdiv u_rdiv (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .i_start(div_start),
    .i_dividend(div_dvd),
    // Divisor as it stands after this cycle's write, matching the dividend
    .i_divisor(num_next),
    .o_done(div_done),
    .o_quot(div_quot)
  );

  // Scale sequencer: derives step counts for 1, 3, 253 and 256 rotations
  always_comb begin
    logic scale_wr;
    logic [31:0] base;
    logic [47:0] prod;
    scale_wr = I_WR && ((I_ADDR == PRM_OFS_NUM) || (I_ADDR == PRM_OFS_DEN));
    base = PRM_STEPS_ROT_BASE;
    prod = '0;
    sc_next = sc_reg;
    sc_st_next = sc_st_reg;
    div_start = 1'b0;
    case (sc_st_reg)
      PRM_SC_IDLE: base = PRM_STEPS_ROT_BASE;
      PRM_SC_STEPS: base = PRM_MARGIN_BASE;
      PRM_SC_MARGIN: base = PRM_SPAN253_BASE;
      PRM_SC_SPAN: base = PRM_RANGE256_BASE;
      default: base = PRM_STEPS_ROT_BASE;
    endcase
    // A restart always begins again with the one-rotation figure
    if (scale_wr) begin
      base = PRM_STEPS_ROT_BASE;
    end
    // Dividend uses the denominator as it stands after this cycle's write
    prod = base * {16'h0000, den_next};
    div_dvd = prod[31:0];
    case (sc_st_reg)
      PRM_SC_IDLE: begin
        if (scale_wr) begin
          div_start = 1'b1;
          sc_st_next = PRM_SC_STEPS;
        end
      end
      PRM_SC_STEPS: begin
        if (div_done) begin
          sc_next.steps_rot = div_quot;
          div_start = 1'b1;
          sc_st_next = PRM_SC_MARGIN;
        end
      end
      PRM_SC_MARGIN: begin
        if (div_done) begin
          sc_next.margin = div_quot;
          div_start = 1'b1;
          sc_st_next = PRM_SC_SPAN;
        end
      end
      PRM_SC_SPAN: begin
        if (div_done) begin
          sc_next.span253 = div_quot;
          div_start = 1'b1;
          sc_st_next = PRM_SC_RANGE;
        end
      end
      PRM_SC_RANGE: begin
        if (div_done) begin
          sc_next.range256 = div_quot;
          sc_st_next = PRM_SC_IDLE;
        end
      end
      default: sc_st_next = PRM_SC_IDLE;
    endcase
    // A new scaling write restarts the chain so the last values win
    if (scale_wr && sc_st_reg != PRM_SC_IDLE) begin
      div_start = 1'b1;
      sc_st_next = PRM_SC_STEPS;
    end
  end

  // Parameter registers, limits and events
  always_comb begin
    logic signed [32:0] ume_lo_win;
    logic signed [32:0] tgt_s;
    ev = '0;
    ume_lo_win = '0;
    tgt_s = wd_s;
    dir_next = dir_reg;
    num_next = num_reg;
    den_next = den_reg;
    ref_next = ref_reg;
    wrap_next = wrap_reg;
    ume_next = ume_reg;
    lim_next = lim_reg;
    mask_next = mask_reg;
    run_next = 1'b0;
    target_next = target_reg;
    if (I_WR) begin
      case (I_ADDR)
        PRM_OFS_CTRL: begin
          dir_next = I_WDATA[PRM_CTRL_DIR_BIT];
          if (I_WDATA[PRM_CTRL_DIR_BIT] != dir_reg) begin
            // New direction restores the default mapping
            ref_next = PRM_REF_RST;
            wrap_next = PRM_WRAP_RST;
            ume_next = PRM_UME_RST;
            lim_next.lower = PRM_LOWER_RST;
            lim_next.upper = PRM_UPPER_RST;
          end
        end
        PRM_OFS_NUM: begin
          if (I_WDATA[15:0] != 16'h0000) begin
            num_next = I_WDATA[15:0];
          end
        end
        PRM_OFS_DEN: begin
          if (I_WDATA[15:0] != 16'h0000) begin
            den_next = I_WDATA[15:0];
          end
        end
        PRM_OFS_REF: ref_next = I_WDATA;
        PRM_OFS_ACT: ref_next = dir_pos + wrap_reg - I_WDATA;
        PRM_OFS_UME: begin
          if (ume_ok) begin
            ume_next = I_WDATA;
            lim_next.lower = cand_lo[31:0];
            lim_next.upper = cand_hi[31:0];
            ev[PRM_ST_UME_OK] = 1'b1;
            ume_lo_win = wd_s - $signed({1'b0, sc_reg.range256});
            if (act_s > wd_s) begin
              wrap_next = wrap_reg - sc_reg.range256;
              ev[PRM_ST_WRAP] = 1'b1;
            end else if (act_s < ume_lo_win) begin
              wrap_next = wrap_reg + sc_reg.range256;
              ev[PRM_ST_WRAP] = 1'b1;
            end
          end else begin
            ev[PRM_ST_UME_REJ] = 1'b1;
          end
        end
        PRM_OFS_LOWER: lim_next.lower = I_WDATA;
        PRM_OFS_UPPER: lim_next.upper = I_WDATA;
        PRM_OFS_TARGET: begin
          if (tgt_s < $signed({lim_reg.lower[31], lim_reg.lower}) ||
              tgt_s > $signed({lim_reg.upper[31], lim_reg.upper})) begin
            ev[PRM_ST_TGT_REJ] = 1'b1;
          end else begin
            target_next = I_WDATA;
            run_next = 1'b1;
          end
        end
        PRM_OFS_MASK: mask_next = I_WDATA[PRM_ST_W-1:0];
        default: ;
      endcase
    end
    if (sc_st_reg == PRM_SC_RANGE && div_done) begin
      ev[PRM_ST_SCALE_DONE] = 1'b1;
    end
  end

  // Sticky status bits, one slice per event; a set beats a write-one clear in the same cycle
  always_comb begin
    st_clr = I_WR && (I_ADDR == PRM_OFS_STATUS);
    irq_next = |(status_next & mask_next);
  end

  for (genvar gi = 0; gi < PRM_ST_W; gi++) begin : g_status
    assign status_next[gi] = ev[gi] | (status_reg[gi] & ~(st_clr & I_WDATA[gi]));
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      status_reg <= PRM_STATUS_RST;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq_reg <= irq_next;
    end
  end

  // Read port: data stand only in the cycle after the strobe, zero otherwise
  always_comb begin
    rdata_next = '0;
    if (I_RD) begin
      case (I_ADDR)
        PRM_OFS_CTRL: rdata_next[PRM_CTRL_DIR_BIT] = dir_reg;
        PRM_OFS_NUM: rdata_next[15:0] = num_reg;
        PRM_OFS_DEN: rdata_next[15:0] = den_reg;
        PRM_OFS_REF: rdata_next = ref_reg;
        PRM_OFS_ACT: rdata_next = act_pos;
        PRM_OFS_UME: rdata_next = ume_reg;
        PRM_OFS_LOWER: rdata_next = lim_reg.lower;
        PRM_OFS_UPPER: rdata_next = lim_reg.upper;
        PRM_OFS_TARGET: rdata_next = target_reg;
        PRM_OFS_STATUS: rdata_next[PRM_ST_W-1:0] = status_reg;
        PRM_OFS_MASK: rdata_next[PRM_ST_W-1:0] = mask_reg;
        PRM_OFS_STEPS: rdata_next = sc_reg.steps_rot;
        PRM_OFS_SCALE: rdata_next[PRM_SCALE_BUSY_BIT] = (sc_st_reg != PRM_SC_IDLE);
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Position sampling, kept apart from the parameter state
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      phys_s1_reg <= '0;
      phys_s2_reg <= '0;
      phys_s3_reg <= '0;
      phys_hold_reg <= '0;
    end else begin
      phys_s1_reg <= I_PHYS_POS;
      phys_s2_reg <= phys_s1_reg;
      phys_s3_reg <= phys_s2_reg;
      phys_hold_reg <= phys_hold_next;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      dir_reg <= 1'b0;
      num_reg <= PRM_NUM_RST;
      den_reg <= PRM_DEN_RST;
      ref_reg <= PRM_REF_RST;
      wrap_reg <= PRM_WRAP_RST;
      ume_reg <= PRM_UME_RST;
      lim_reg.lower <= PRM_LOWER_RST;
      lim_reg.upper <= PRM_UPPER_RST;
      sc_reg.steps_rot <= PRM_STEPS_ROT_BASE;
      sc_reg.margin <= PRM_MARGIN_BASE;
      sc_reg.span253 <= PRM_SPAN253_BASE;
      sc_reg.range256 <= PRM_RANGE256_BASE;
      sc_st_reg <= PRM_SC_IDLE;
      mask_reg <= PRM_MASK_RST;
      run_reg <= 1'b0;
      target_reg <= '0;
    end else begin
      dir_reg <= dir_next;
      num_reg <= num_next;
      den_reg <= den_next;
      ref_reg <= ref_next;
      wrap_reg <= wrap_next;
      ume_reg <= ume_next;
      lim_reg <= lim_next;
      sc_reg <= sc_next;
      sc_st_reg <= sc_st_next;
      mask_reg <= mask_next;
      run_reg <= run_next;
      target_reg <= target_next;
    end
  end

  assign O_RDATA = rdata_reg;
  assign O_RUN_REQ = run_reg;
  assign O_TARGET = target_reg;
  assign O_IRQ = irq_reg;
endmodule
`default_nettype wire

/* rtl/prm_pkg.sv */
`default_nettype none
package prm_pkg;
  // Register byte offsets
  localparam logic [7:0] PRM_OFS_CTRL = 8'h00;
  localparam logic [7:0] PRM_OFS_NUM = 8'h04;
  localparam logic [7:0] PRM_OFS_DEN = 8'h08;
  localparam logic [7:0] PRM_OFS_REF = 8'h0c;
  localparam logic [7:0] PRM_OFS_ACT = 8'h10;
  localparam logic [7:0] PRM_OFS_UME = 8'h14;
  localparam logic [7:0] PRM_OFS_LOWER = 8'h18;
  localparam logic [7:0] PRM_OFS_UPPER = 8'h1c;
  localparam logic [7:0] PRM_OFS_TARGET = 8'h20;
  localparam logic [7:0] PRM_OFS_STATUS = 8'h24;
  localparam logic [7:0] PRM_OFS_MASK = 8'h28;
  localparam logic [7:0] PRM_OFS_STEPS = 8'h2c;
  localparam logic [7:0] PRM_OFS_SCALE = 8'h30;

  // Field positions
  localparam int PRM_CTRL_DIR_BIT = 0;
  localparam int PRM_SCALE_BUSY_BIT = 0;
  localparam int PRM_ST_UME_OK = 0;
  localparam int PRM_ST_UME_REJ = 1;
  localparam int PRM_ST_TGT_REJ = 2;
  localparam int PRM_ST_WRAP = 3;
  localparam int PRM_ST_SCALE_DONE = 4;
  localparam int PRM_ST_W = 5;

  // Scaling base figures, in steps at unity scaling
  localparam logic [31:0] PRM_STEPS_ROT_BASE = 32'h0000_0190;   // 400 steps, 1 rotation
  localparam logic [31:0] PRM_MARGIN_BASE = 32'h0000_04b0;      // 1,200 steps, 3 rotations
  localparam logic [31:0] PRM_SPAN253_BASE = 32'h0001_8b50;     // 101,200 steps, 253 rotations
  localparam logic [31:0] PRM_RANGE256_BASE = 32'h0001_9000;    // 102,400 steps, 256 rotations

  // Values after reset (factory default state)
  localparam logic [15:0] PRM_NUM_RST = 16'h0190;
  localparam logic [15:0] PRM_DEN_RST = 16'h0190;
  localparam logic [31:0] PRM_UME_RST = 32'h0001_9000;          // 102,400
  localparam logic [31:0] PRM_LOWER_RST = 32'h0000_04b0;        // 1,200
  localparam logic [31:0] PRM_UPPER_RST = 32'h0001_8b50;        // 101,200
  localparam logic [31:0] PRM_REF_RST = 32'h0000_0000;
  localparam logic [31:0] PRM_WRAP_RST = 32'h0000_0000;
  localparam logic [PRM_ST_W-1:0] PRM_STATUS_RST = 5'h00;
  localparam logic [PRM_ST_W-1:0] PRM_MASK_RST = 5'h00;

  // Divider iterations
  localparam int PRM_DIV_STEPS = 32;

  typedef struct packed {
    logic [31:0] lower;
    logic [31:0] upper;
  } prm_limits_t;

  typedef struct packed {
    logic [31:0] margin;
    logic [31:0] span253;
    logic [31:0] range256;
    logic [31:0] steps_rot;
  } prm_scale_t;

  typedef enum {
    PRM_SC_IDLE,
    PRM_SC_STEPS,
    PRM_SC_MARGIN,
    PRM_SC_SPAN,
    PRM_SC_RANGE
  } prm_sc_state_t;
endpackage
`default_nettype wire

/* rtl/prm_rdiv.sv */
`default_nettype none
module prm_rdiv
  import prm_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Request
  input wire logic i_start,
  input wire logic [31:0] i_dividend,
  input wire logic [15:0] i_divisor,
  // Result
  output logic o_done,
  output logic [31:0] o_quot
);
  // Restoring divider; rounds to nearest by adding half the divisor first
  logic [31:0] dvd_reg, dvd_next;
  logic [32:0] rem_reg, rem_next;
  logic [31:0] quot_reg, quot_next;
  logic [5:0] cnt_reg, cnt_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;

  always_comb begin
    logic [32:0] trial;
    trial = '0;
    dvd_next = dvd_reg;
    rem_next = rem_reg;
    quot_next = quot_reg;
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (i_start) begin
      dvd_next = i_dividend + {16'h0000, 1'b0, i_divisor[15:1]};
      rem_next = '0;
      quot_next = '0;
      cnt_next = 6'(PRM_DIV_STEPS);
      busy_next = 1'b1;
    end else if (busy_reg) begin
      trial = {rem_reg[31:0], dvd_reg[31]};
      dvd_next = {dvd_reg[30:0], 1'b0};
      if (trial >= {17'h0_0000, i_divisor}) begin
        rem_next = trial - {17'h0_0000, i_divisor};
        quot_next = {quot_reg[30:0], 1'b1};
      end else begin
        rem_next = trial;
        quot_next = {quot_reg[30:0], 1'b0};
      end
      cnt_next = cnt_reg - 6'h01;
      if (cnt_reg == 6'h01) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dvd_reg <= '0;
      rem_reg <= '0;
      quot_reg <= '0;
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      dvd_reg <= dvd_next;
      rem_reg <= rem_next;
      quot_reg <= quot_next;
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign o_done = done_reg;
  assign o_quot = quot_reg;
endmodule
`default_nettype wire

/* dv/prm_master.sv */
`default_nettype none
module prm_master (
  // Clock
  input wire logic i_clk,
  // Register port toward the device
  output logic [7:0] o_addr,
  output logic [31:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_addr = 8'h00;
    o_wdata = 32'h0;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // Entered just after a rising edge, returns just after the edge that takes the strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    o_rd <= 1'b0;
    @(posedge i_clk);
  endtask
  // Write data is not meaningful on a read, so it keeps moving rather than holding a stale value
  task automatic rd(input logic [7:0] a);
    o_addr <= a;
    o_wdata <= ~o_wdata;
    o_rd <= 1'b1;
    o_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic idle();
    o_addr <= ~o_addr;
    o_wdata <= ~o_wdata;
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

/* dv/prm_range_map_asserts.sv */
`default_nettype none
module prm_range_map_asserts
  import prm_pkg::*;
(
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RSTN,
  // Watched ports
  input wire logic [31:0] I_PHYS_POS,
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [31:0] O_RDATA,
  input wire logic O_RUN_REQ,
  input wire logic [31:0] O_TARGET,
  input wire logic O_IRQ
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);
  // Default limits are only known until software touches scaling or range
  logic dflt_reg, dflt_next, unity_reg, unity_next, wr_tgt, in_rng;
  logic [4:0] mask_reg, mask_next;
  always_comb begin
    wr_tgt = I_WR && I_ADDR == PRM_OFS_TARGET;
    in_rng = $signed(I_WDATA) >= $signed(PRM_LOWER_RST) && $signed(I_WDATA) <= $signed(PRM_UPPER_RST);
    dflt_next = dflt_reg && !(I_WR && I_ADDR inside {PRM_OFS_CTRL, PRM_OFS_NUM, PRM_OFS_DEN,
      PRM_OFS_UME, PRM_OFS_LOWER, PRM_OFS_UPPER});
    unity_next = unity_reg && !(I_WR && I_ADDR inside {PRM_OFS_NUM, PRM_OFS_DEN});
    mask_next = (I_WR && I_ADDR == PRM_OFS_MASK) ? I_WDATA[4:0] : mask_reg;
  end
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      dflt_reg <= 1'b1;
      unity_reg <= 1'b1;
      mask_reg <= 5'h00;
    end else begin
      dflt_reg <= dflt_next;
      unity_reg <= unity_next;
      mask_reg <= mask_next;
    end
  end
  sequence s_ume_rd;
    unity_reg && I_WR && I_ADDR == PRM_OFS_UME ##1 I_RD && I_ADDR == PRM_OFS_LOWER
      ##1 I_RD && I_ADDR == PRM_OFS_UME;
  endsequence
  a_run_src: assert property (O_RUN_REQ |-> $past(I_WR) && $past(I_ADDR) == PRM_OFS_TARGET)
    else $error("run request without target write");
  a_tgt_ok: assert property (dflt_reg && wr_tgt && in_rng |=> O_RUN_REQ && O_TARGET == $past(I_WDATA))
    else $error("in-range target not started");
  a_tgt_rej: assert property (dflt_reg && wr_tgt && !in_rng |=> !O_RUN_REQ)
    else $error("margin target started");
  a_ume_dflt: assert property (dflt_reg && I_RD && I_ADDR == PRM_OFS_UME |=> O_RDATA == PRM_UME_RST)
    else $error("default mapping end wrong");
  a_lower_dflt: assert property (dflt_reg && I_RD && I_ADDR == PRM_OFS_LOWER |=> O_RDATA == PRM_LOWER_RST)
    else $error("default lower limit wrong");
  a_steps_unity: assert property (unity_reg && I_RD && I_ADDR == PRM_OFS_STEPS |=> O_RDATA == 32'h190)
    else $error("steps per rotation wrong");
  a_ref_direct: assert property (I_WR && I_ADDR == PRM_OFS_REF ##1 I_RD && I_ADDR == PRM_OFS_REF
    |=> O_RDATA == $past(I_WDATA, 2)) else $error("referencing value not written");
  a_ume_lower: assert property (s_ume_rd ##1 O_RDATA == $past(I_WDATA, 3)
    |-> $past(O_RDATA) == $past(I_WDATA, 3) - PRM_SPAN253_BASE) else $error("lower limit not recomputed");
  a_irq_off: assert property (mask_reg == 5'h00 && $past(mask_reg) == 5'h00 |-> !O_IRQ)
    else $error("interrupt while all masked");
  a_irq_raise: assert property (dflt_reg && mask_reg[PRM_ST_TGT_REJ] && wr_tgt && !in_rng
    |-> ##[1:2] O_IRQ) else $error("no interrupt on target refusal");
  c_run_b2b: cover property (O_RUN_REQ ##1 O_RUN_REQ);
  c_irq: cover property ($rose(O_IRQ));
  c_ume: cover property (s_ume_rd);
endmodule
bind prm_range_map prm_range_map_asserts u_chk (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_PHYS_POS(I_PHYS_POS),
  .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .O_RUN_REQ(O_RUN_REQ), .O_TARGET(O_TARGET), .O_IRQ(O_IRQ));
`default_nettype wire

/* dv/prm_range_map_bench.sv */
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module prm_range_map_bench
  import prm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] NM = 32'h7;
  localparam logic [31:0] DN = 32'h3;
  logic I_CLK;
  logic I_RSTN = 1'b0;
  logic [31:0] I_PHYS_POS = 32'h0000_c800;
  logic [7:0] I_ADDR;
  logic [31:0] I_WDATA, O_RDATA, O_TARGET;
  logic I_WR, I_RD, O_RUN_REQ, O_IRQ;
  logic rd_d = 1'b0;
  logic [31:0] last_rd, act, cur, m_s, s_s, lo, t_e;
  logic [63:0] e_q;
  logic [63:0] expq[$];
  logic [31:0] tq[$];
  int mismatches = 0;
  int num_checks = 0;
  int seed_r;
  prm_range_map dut (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_PHYS_POS(I_PHYS_POS), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_RUN_REQ(O_RUN_REQ),
    .O_TARGET(O_TARGET), .O_IRQ(O_IRQ));
  prm_master mst (.i_clk(I_CLK), .o_addr(I_ADDR), .o_wdata(I_WDATA), .o_wr(I_WR), .o_rd(I_RD));
  initial begin
    I_CLK = 1'b0;
    forever #4 I_CLK = ~I_CLK;
  end
  // Read data stand for one cycle only, so they are taken mid-cycle
  always @(posedge I_CLK) rd_d <= I_RD;
  always @(negedge I_CLK) begin
    if (rd_d) begin
      last_rd = O_RDATA;
      e_q = expq.size() ? expq.pop_front() : {32'hffff_ffff, ~O_RDATA};
      if (e_q[63:32] !== 32'h0) `CHK(O_RDATA & e_q[63:32], e_q[31:0])
    end
    if (O_RUN_REQ === 1'b1) begin
      t_e = tq.size() ? tq.pop_front() : ~O_TARGET;
      `CHK(O_TARGET, t_e)
    end
  end
  function automatic logic [31:0] rnd(input logic [31:0] x);
    return (x * DN + NM / 32'h2) / NM;
  endfunction
  task automatic rx(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m = 32'hffff_ffff);
    expq.push_back({m, v});
    mst.rd(a);
  endtask
  task automatic tgt(input logic [31:0] t, input bit ok);
    if (ok) tq.push_back(t);
    mst.wr(PRM_OFS_TARGET, t);
  endtask
  task automatic irq(input logic e);
    mst.idle();
    mst.idle();
    @(negedge I_CLK);
    `CHK(O_IRQ, e)
    @(posedge I_CLK);
  endtask
  task automatic ume(input logic [31:0] w, input bit ok);
    if (ok) cur = w;
    mst.wr(PRM_OFS_UME, w);
    rx(PRM_OFS_LOWER, cur - s_s);
    rx(PRM_OFS_UME, cur);
    rx(PRM_OFS_UPPER, cur - m_s);
    rx(PRM_OFS_STATUS, ok ? 32'h1 : 32'h2, 32'h3);
    mst.wr(PRM_OFS_STATUS, 32'h3);
  endtask
  // Bounded poll of the busy flag; the conversion length is only approximate
  task automatic wait_scale();
    int n;
    n = 0;
    last_rd = 32'h1;
    while (last_rd[0] !== 1'b0 && n < 300) begin
      rx(PRM_OFS_SCALE, 32'h0, 32'h0);
      mst.idle();
      n++;
    end
    `CHK(n < 300, 1'b1)
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    seed_r = $urandom(32'h0432);
    repeat (8) @(posedge I_CLK);
    I_RSTN <= 1'b1;
    @(posedge I_CLK);
    rx(PRM_OFS_UME, PRM_UME_RST);
    rx(PRM_OFS_LOWER, PRM_LOWER_RST);
    rx(PRM_OFS_UPPER, PRM_UPPER_RST);
    rx(PRM_OFS_STEPS, PRM_STEPS_ROT_BASE);
    rx(PRM_OFS_ACT, 32'h0000_c800);
    rx(8'hfc, 32'h0);
    mst.wr(PRM_OFS_MASK, 32'h4);
    tgt(PRM_LOWER_RST, 1'b1);
    tgt(PRM_UPPER_RST, 1'b1);
    tgt(PRM_LOWER_RST - 32'h1, 1'b0);
    tgt(PRM_UPPER_RST + 32'h1, 1'b0);
    repeat (4) tgt(PRM_LOWER_RST + $urandom_range(32'h186a0), 1'b1);
    irq(1'b1);
    mst.wr(PRM_OFS_STATUS, 32'h1f);
    irq(1'b0);
    mst.wr(PRM_OFS_REF, 32'h64);
    rx(PRM_OFS_REF, 32'h64);
    rx(PRM_OFS_ACT, 32'h0000_c800 - 32'h64);
    mst.wr(PRM_OFS_ACT, 32'h0);
    rx(PRM_OFS_REF, 32'h0000_c800);
    rx(PRM_OFS_ACT, 32'h0);
    mst.wr(PRM_OFS_REF, 32'h0);
    act = 32'h0000_c800;
    cur = PRM_UME_RST;
    m_s = PRM_MARGIN_BASE;
    s_s = PRM_SPAN253_BASE;
    ume(act + m_s, 1'b1);
    ume(act + m_s - 32'h1, 1'b0);
    ume(act + s_s + 32'h1, 1'b0);
    ume(act + s_s, 1'b1);
    lo = cur - s_s + 32'h3e8;
    mst.wr(PRM_OFS_LOWER, lo);
    tgt(lo - 32'h1, 1'b0);
    tgt(lo, 1'b1);
    mst.wr(PRM_OFS_CTRL, 32'h1);
    rx(PRM_OFS_ACT, 32'hffff_3800);
    rx(PRM_OFS_UME, PRM_UME_RST);
    mst.wr(PRM_OFS_NUM, NM);
    wait_scale();
    mst.wr(PRM_OFS_DEN, DN);
    wait_scale();
    mst.wr(PRM_OFS_NUM, 32'h0);
    rx(PRM_OFS_NUM, NM);
    rx(PRM_OFS_STEPS, rnd(PRM_STEPS_ROT_BASE));
    rx(PRM_OFS_STATUS, 32'h10, 32'h10);
    mst.wr(PRM_OFS_REF, 32'h0);
    act = 32'hffff_3800;
    m_s = rnd(PRM_MARGIN_BASE);
    s_s = rnd(PRM_SPAN253_BASE);
    ume(act + m_s, 1'b1);
    ume(act + m_s - 32'h1, 1'b0);
    ume(act + s_s + 32'h1, 1'b0);
    ume(act + s_s, 1'b1);
    mst.idle();
    mst.idle();
    `CHK(tq.size() + expq.size(), 0)
    complete_run();
  end
  initial begin
    #100000;
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire
